/* core/dac_cmd_pkg.sv */
package dac_cmd_pkg;

    // word layout, most significant bit first on the link
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 10;
    localparam int NUM_CH    = 4;
    localparam int ADDR_HI   = 15;
    localparam int ADDR_LO   = 14;
    localparam int MODE_HI   = 13;
    localparam int MODE_LO   = 12;
    localparam int CODE_HI   = 11;
    localparam int CODE_LO   = 2;   // two lowest data bits are dropped
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h0f;
    localparam logic [BIT_CNT_W-1:0] ALL_BITS = 5'h10;

    // operating modes carried in the two mode bits
    typedef enum logic [1:0] {
        MODE_WRITE_HOLD   = 2'h0,
        MODE_WRITE_UPDATE = 2'h1,
        MODE_WRITE_ALL    = 2'h2,
        MODE_POWER_DOWN   = 2'h3
    } op_mode_t;

    // termination codes while powered down
    localparam logic [1:0] TERM_HIGHZ = 2'h0;
    localparam logic [1:0] TERM_2K5   = 2'h1;
    localparam logic [1:0] TERM_100K  = 2'h2;

    // register map, byte addresses
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_LAST_WORD = 8'h08;
    localparam logic [7:0] REG_CODE_A    = 8'h10;
    localparam logic [7:0] REG_CODE_B    = 8'h14;
    localparam logic [7:0] REG_CODE_C    = 8'h18;
    localparam logic [7:0] REG_CODE_D    = 8'h1c;

    // field positions and reset values
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'h1;
    localparam int ST_PD_BIT   = 0;
    localparam int ST_TERM_LO  = 1;
    localparam int ST_TERM_HI  = 2;
    localparam int ST_WAKE_BIT = 3;
    localparam int ST_BUSY_BIT = 4;
    localparam logic [1:0] TERM_RESET = 2'h0;

    // wake-up interval, a least time, rounded up to whole cycles
    localparam int CLK_MHZ         = 20;
    localparam int WAKE_UP_TIME_NS = 6000;
    localparam int WAKE_CNT_W      = 8;
    localparam logic [WAKE_CNT_W-1:0] WAKE_CYCLES =
        WAKE_CNT_W'((WAKE_UP_TIME_NS * CLK_MHZ + 999) / 1000);

endpackage

/* core/dac_code_bank.sv */
`timescale 1ns/10ps
module dac_code_bank (
    input  wire logic                                       clk,      // system clock
    input  wire logic                                       rst_n,    // async reset
    input  wire logic                                       ce,       // clock enable
    input  wire logic                                       load,     // completed frame pulse
    input  wire logic [1:0]                                 addr,     // channel select
    input  wire logic [1:0]                                 mode,     // op mode bits
    input  wire logic [dac_cmd_pkg::CODE_BITS-1:0]          code,     // new code
    output logic [dac_cmd_pkg::NUM_CH-1:0][dac_cmd_pkg::CODE_BITS-1:0] in_code, // input regs
    output logic [dac_cmd_pkg::NUM_CH-1:0][dac_cmd_pkg::CODE_BITS-1:0] out_code // output regs
);

    logic upd_all;
    logic all_wr;
    logic one_wr;

    // decode which registers a completed frame touches
    assign all_wr  = load && (mode == dac_cmd_pkg::MODE_WRITE_ALL);
    assign one_wr  = load && ((mode == dac_cmd_pkg::MODE_WRITE_HOLD) ||
                              (mode == dac_cmd_pkg::MODE_WRITE_UPDATE));
    assign upd_all = load && ((mode == dac_cmd_pkg::MODE_WRITE_UPDATE) ||
                              (mode == dac_cmd_pkg::MODE_WRITE_ALL));

    for (genvar ch = 0; ch < dac_cmd_pkg::NUM_CH; ch++) begin : g_ch
        logic wr_here;
        assign wr_here = all_wr || (one_wr && (addr == 2'(ch)));

        // power-down frames fall through both ifs, so codes survive it
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                in_code[ch]  <= '0;
                out_code[ch] <= '0;
            end else if (ce) begin
                if (wr_here) begin
                    in_code[ch] <= code;
                end
                if (upd_all) begin
                    // the register written in this frame goes straight out
                    out_code[ch] <= wr_here ? code : in_code[ch];
                end
            end
        end

        property p_pd_keeps_code;
            @(posedge clk) disable iff (!rst_n)
            (ce && load && mode == dac_cmd_pkg::MODE_POWER_DOWN)
                |=> $stable(in_code[ch]) && $stable(out_code[ch]);
        endproperty
        a_pd_keeps_code: assert property (p_pd_keeps_code)
            else $error("power-down frame altered a code register");

        property p_hold_no_update;
            @(posedge clk) disable iff (!rst_n)
            (ce && load && mode == dac_cmd_pkg::MODE_WRITE_HOLD && addr == 2'(ch))
                |=> in_code[ch] == $past(code) && $stable(out_code[ch]);
        endproperty
        a_hold_no_update: assert property (p_hold_no_update)
            else $error("write-hold frame wrong on addressed channel");
    end

endmodule // dac_code_bank

/* core/dac_serial_port.sv */
`timescale 1ns/10ps
// What this block does
// - frame select low, shift data on falling clock
// - sixteenth fall completes word and executes it
// - select may stay low or rise afterwards
// - extra bits after sixteen are ignored
// - early select rise aborts frame entirely
// - word is address, mode, then twelve data
// - four modes: hold, update, all, power down
// - codes are straight binary, msb first
// - reset clears codes, outputs at zero
// - mode 11 powers down all channels
// - address bits choose power-down termination
// - power-down leaves code registers unchanged
// - codes kept on wake unless rewritten
// - each code register holds 0 to 1023
// - wake interval starts at sixteenth fall
module dac_serial_port (
    input  wire logic                              clk,          // 20 MHz system clock
    input  wire logic                              rst_n,        // async reset, active low
    input  wire logic                              ce,           // clock enable, freezes all
    input  wire logic                              frame_sel_n,  // link frame select, active low
    input  wire logic                              link_clk,     // link serial clock pin
    input  wire logic                              link_data,    // link serial data pin
    input  wire logic [7:0]                        addr,         // register byte address
    input  wire logic [31:0]                       wdata,        // register write data
    input  wire logic                              wr,           // write strobe
    input  wire logic                              rd,           // read strobe
    output logic      [31:0]                       rdata,        // read data, cycle after rd
    output logic      [dac_cmd_pkg::CODE_BITS-1:0] out_code_a,   // channel a output code
    output logic      [dac_cmd_pkg::CODE_BITS-1:0] out_code_b,   // channel b output code
    output logic      [dac_cmd_pkg::CODE_BITS-1:0] out_code_c,   // channel c output code
    output logic      [dac_cmd_pkg::CODE_BITS-1:0] out_code_d,   // channel d output code
    output logic                                   out_drive_en, // outputs actively driven
    output logic      [1:0]                        out_term,     // power-down termination
    output logic                                   powered_down, // power-down state
    output logic                                   waking        // wake-up interval running
);

    typedef enum logic [1:0] {LINK_IDLE, LINK_SHIFT, LINK_HOLD} link_state_t;

    link_state_t                          state_r;
    logic [2:0]                           pins_s;
    logic                                 sel_n_s;
    logic                                 sclk_s;
    logic                                 data_s;
    logic                                 sclk_prev_r;
    logic                                 sclk_fall;
    logic [dac_cmd_pkg::BIT_CNT_W-1:0]    cnt_r;
    logic [dac_cmd_pkg::WORD_BITS-1:0]    shift_r;
    logic [dac_cmd_pkg::WORD_BITS-1:0]    word_r;
    logic                                 done_r;
    logic                                 ctrl_en_r;
    logic                                 pd_r;
    logic [1:0]                           term_r;
    logic [dac_cmd_pkg::WAKE_CNT_W-1:0]   wake_cnt_r;
    logic [31:0]                          rdata_nxt;
    logic [1:0]                           w_addr;
    logic [1:0]                           w_mode;
    logic [dac_cmd_pkg::CODE_BITS-1:0]    w_code;
    logic [dac_cmd_pkg::NUM_CH-1:0][dac_cmd_pkg::CODE_BITS-1:0] in_code;
    logic [dac_cmd_pkg::NUM_CH-1:0][dac_cmd_pkg::CODE_BITS-1:0] out_code;

    // select enters inverted so the zero-reset flops read as idle, no false start
    pin_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d_in  ({!frame_sel_n, link_clk, link_data}),
        .d_out (pins_s)
    );

    assign sel_n_s = !pins_s[2];
    assign sclk_s  = pins_s[1];
    assign data_s  = pins_s[0];

    // falling edge of the sampled link clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_r <= 1'b0;
        end else if (ce) begin
            sclk_prev_r <= sclk_s;
        end
    end

    assign sclk_fall = sclk_prev_r && !sclk_s;

    // frame sequencer; a select rise in any state ends the frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= LINK_IDLE;
            cnt_r   <= '0;
        end else if (ce) begin
            if (sel_n_s) begin
                state_r <= LINK_IDLE;
                cnt_r   <= '0;
            end else begin
                unique case (state_r)
                    LINK_IDLE: begin
                        // a clock fall seen with the select fall is not taken
                        if (ctrl_en_r) begin
                            state_r <= LINK_SHIFT;
                        end else begin
                            state_r <= LINK_HOLD;
                        end
                    end
                    LINK_SHIFT: begin
                        if (sclk_fall) begin
                            cnt_r <= cnt_r + 5'h01;
                            if (cnt_r == dac_cmd_pkg::LAST_BIT) begin
                                state_r <= LINK_HOLD;
                            end
                        end
                    end
                    LINK_HOLD: begin
                        // wait for select high; clocks and data are dropped
                        state_r <= LINK_HOLD;
                    end
                endcase
            end
        end
    end

    // serial input register, msb arrives first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= '0;
        end else if (ce) begin
            if (state_r == LINK_SHIFT && !sel_n_s && sclk_fall) begin
                shift_r <= {shift_r[dac_cmd_pkg::WORD_BITS-2:0], data_s};
            end
        end
    end

    // completed word latch and one-cycle execute pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_r <= '0;
            done_r <= 1'b0;
        end else if (ce) begin
            done_r <= 1'b0;
            if (state_r == LINK_SHIFT && !sel_n_s && sclk_fall &&
                cnt_r == dac_cmd_pkg::LAST_BIT) begin
                word_r <= {shift_r[dac_cmd_pkg::WORD_BITS-2:0], data_s};
                done_r <= 1'b1;
            end
        end
    end

    // field split of the completed word
    assign w_addr = word_r[dac_cmd_pkg::ADDR_HI:dac_cmd_pkg::ADDR_LO];
    assign w_mode = word_r[dac_cmd_pkg::MODE_HI:dac_cmd_pkg::MODE_LO];
    assign w_code = word_r[dac_cmd_pkg::CODE_HI:dac_cmd_pkg::CODE_LO];

    dac_code_bank u_bank (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .load     (done_r),
        .addr     (w_addr),
        .mode     (w_mode),
        .code     (w_code),
        .in_code  (in_code),
        .out_code (out_code)
    );

    // power-down state and termination choice
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_r   <= 1'b0;
            term_r <= dac_cmd_pkg::TERM_RESET;
        end else if (ce && done_r) begin
            if (w_mode == dac_cmd_pkg::MODE_POWER_DOWN) begin
                pd_r   <= 1'b1;
                term_r <= (w_addr == 2'h3) ? dac_cmd_pkg::TERM_HIGHZ : w_addr;
            end else begin
                pd_r   <= 1'b0;
            end
        end
    end

    // wake counter, started by the frame that leaves power-down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt_r <= '0;
        end else if (ce) begin
            if (done_r && pd_r && w_mode != dac_cmd_pkg::MODE_POWER_DOWN) begin
                wake_cnt_r <= dac_cmd_pkg::WAKE_CYCLES;
            end else if (done_r && w_mode == dac_cmd_pkg::MODE_POWER_DOWN) begin
                wake_cnt_r <= '0;
            end else if (wake_cnt_r != '0) begin
                wake_cnt_r <= wake_cnt_r - 8'h01;
            end
        end
    end

    assign out_code_a   = out_code[0];
    assign out_code_b   = out_code[1];
    assign out_code_c   = out_code[2];
    assign out_code_d   = out_code[3];
    assign powered_down = pd_r;
    assign waking       = (wake_cnt_r != '0);
    assign out_term     = term_r;
    // outputs stay off until the wake interval has run out
    assign out_drive_en = !pd_r && (wake_cnt_r == '0);

    // control register; link enable gates the start of a frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_en_r <= dac_cmd_pkg::CTRL_ENABLE_RESET;
        end else if (ce && wr && addr == dac_cmd_pkg::REG_CTRL) begin
            ctrl_en_r <= wdata[dac_cmd_pkg::CTRL_ENABLE_BIT];
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        rdata_nxt = 32'h0;
        unique case (addr)
            dac_cmd_pkg::REG_CTRL: begin
                rdata_nxt[dac_cmd_pkg::CTRL_ENABLE_BIT] = ctrl_en_r;
            end
            dac_cmd_pkg::REG_STATUS: begin
                rdata_nxt[dac_cmd_pkg::ST_PD_BIT]   = pd_r;
                rdata_nxt[dac_cmd_pkg::ST_TERM_HI:dac_cmd_pkg::ST_TERM_LO] = term_r;
                rdata_nxt[dac_cmd_pkg::ST_WAKE_BIT] = (wake_cnt_r != '0);
                rdata_nxt[dac_cmd_pkg::ST_BUSY_BIT] = (state_r == LINK_SHIFT);
            end
            dac_cmd_pkg::REG_LAST_WORD: begin
                rdata_nxt[dac_cmd_pkg::WORD_BITS-1:0] = word_r;
            end
            dac_cmd_pkg::REG_CODE_A: begin
                rdata_nxt[dac_cmd_pkg::CODE_BITS-1:0] = out_code[0];
            end
            dac_cmd_pkg::REG_CODE_B: begin
                rdata_nxt[dac_cmd_pkg::CODE_BITS-1:0] = out_code[1];
            end
            dac_cmd_pkg::REG_CODE_C: begin
                rdata_nxt[dac_cmd_pkg::CODE_BITS-1:0] = out_code[2];
            end
            dac_cmd_pkg::REG_CODE_D: begin
                rdata_nxt[dac_cmd_pkg::CODE_BITS-1:0] = out_code[3];
            end
            default: begin
                rdata_nxt = 32'h0;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else if (ce) begin
            rdata <= rd ? rdata_nxt : 32'h0;
        end
    end

    property p_shift_bit;
        @(posedge clk) disable iff (!rst_n)
        (ce && state_r == LINK_SHIFT && !sel_n_s && sclk_fall)
            |=> shift_r[0] == $past(data_s) && cnt_r == $past(cnt_r) + 5'h01;
    endproperty
    a_shift_bit: assert property (p_shift_bit)
        else $error("link bit not shifted on clock fall");

    property p_done_on_sixteenth;
        @(posedge clk) disable iff (!rst_n)
        (ce && state_r == LINK_SHIFT && !sel_n_s && sclk_fall &&
         cnt_r == dac_cmd_pkg::LAST_BIT)
            |=> done_r && cnt_r == dac_cmd_pkg::ALL_BITS && state_r == LINK_HOLD;
    endproperty
    a_done_on_sixteenth: assert property (p_done_on_sixteenth)
        else $error("sixteenth fall did not complete the word");

    property p_ignore_extra;
        @(posedge clk) disable iff (!rst_n)
        (ce && state_r == LINK_HOLD && sclk_fall)
            |=> !done_r && $stable(shift_r) && $stable(word_r);
    endproperty
    a_ignore_extra: assert property (p_ignore_extra)
        else $error("extra link clock changed state");

    property p_abort;
        @(posedge clk) disable iff (!rst_n)
        (ce && sel_n_s && state_r == LINK_SHIFT)
            |=> state_r == LINK_IDLE && cnt_r == '0 && !done_r;
    endproperty
    a_abort: assert property (p_abort)
        else $error("short frame was not aborted");

    property p_pd_enter;
        @(posedge clk) disable iff (!rst_n)
        (ce && done_r && w_mode == dac_cmd_pkg::MODE_POWER_DOWN)
            |=> pd_r && !out_drive_en;
    endproperty
    a_pd_enter: assert property (p_pd_enter)
        else $error("mode 11 did not power down");

    property p_term_select;
        @(posedge clk) disable iff (!rst_n)
        (ce && done_r && w_mode == dac_cmd_pkg::MODE_POWER_DOWN)
            |=> out_term == ((($past(w_addr) == 2'h1) || ($past(w_addr) == 2'h2)) ?
                             $past(w_addr) : dac_cmd_pkg::TERM_HIGHZ);
    endproperty
    a_term_select: assert property (p_term_select)
        else $error("wrong power-down termination");

    property p_wake_from_frame;
        @(posedge clk) disable iff (!rst_n)
        (ce && done_r && pd_r && w_mode != dac_cmd_pkg::MODE_POWER_DOWN)
            |=> !pd_r && waking && wake_cnt_r == dac_cmd_pkg::WAKE_CYCLES;
    endproperty
    a_wake_from_frame: assert property (p_wake_from_frame)
        else $error("wake interval not started by leaving frame");

    property p_read_one_cycle;
        @(posedge clk) disable iff (!rst_n)
        (ce && !rd) |=> rdata == 32'h0;
    endproperty
    a_read_one_cycle: assert property (p_read_one_cycle)
        else $error("read data outside the answer cycle");

endmodule // dac_serial_port

/* core/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,    // system clock
    input  wire logic             rst_n,  // async reset, active low
    input  wire logic             ce,     // clock enable
    input  wire logic [WIDTH-1:0] d_in,   // asynchronous pin levels
    output logic      [WIDTH-1:0] d_out   // synchronised levels
);

    logic [WIDTH-1:0] meta_r;

    // two flops per bit; only the second flop reads the first
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_r[i] <= 1'b0;
                d_out[i]  <= 1'b0;
            end else if (ce) begin
                meta_r[i] <= d_in[i];
                d_out[i]  <= meta_r[i];
            end
        end
    end

endmodule // pin_sync

/* verification/link_master.sv */
`timescale 1ns/10ps
module link_master (
    output logic frame_sel_n, // frame select, active low
    output logic link_clk,    // serial clock, idles high
    output logic link_data    // serial data
);
    // clock stands still, select high, data low outside frames
    initial begin
        frame_sel_n = 1'b1;
        link_clk = 1'b1;
        link_data = 1'b0;
    end
    // off-grid wait after select fall keeps it well clear of any clock fall
    task automatic send(input logic [23:0] bits, input int nf);
        frame_sel_n = 1'b0;
        #113;
        for (int i = 0; i < nf; i++) begin
            link_data = bits[23-i]; // msb first
            #200 link_clk = 1'b0;
            #200 link_clk = 1'b1;
        end
        #100 frame_sel_n = 1'b1;
        link_data = 1'b0;
        #400; // select high time before any next frame
    endtask
endmodule // link_master

/* verification/quad_dac_serial_command_port_test.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin tmp = 64'(e); checks_done++; if (64'(g) !== tmp) begin n_mismatch++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, tmp); end end
module quad_dac_serial_command_port_test;
    logic        clk, rst_n, ce, wr, rd, rd_q, smp, en, pd_m, wake_m;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [9:0]  out_code_a, out_code_b, out_code_c, out_code_d;
    logic        out_drive_en, powered_down, waking;
    logic [1:0]  out_term, term_m;
    logic [9:0]  in_m [4], out_m [4];
    logic [15:0] last_m;
    logic [63:0] tmp;
    logic [44:0] q_link [$];
    logic [31:0] q_reg [$];
    int          n_mismatch, checks_done;
    wire         frame_sel_n, link_clk, link_data;
    // term only means something while powered down
    wire [44:0]  seen = {out_code_a, out_code_b, out_code_c, out_code_d, powered_down,
                         powered_down ? out_term : 2'h0, out_drive_en, waking};

    dac_serial_port DUT (.clk, .rst_n, .ce, .frame_sel_n, .link_clk, .link_data,
        .addr, .wdata, .wr, .rd, .rdata, .out_code_a, .out_code_b, .out_code_c,
        .out_code_d, .out_drive_en, .out_term, .powered_down, .waking);
    link_master lm (.frame_sel_n, .link_clk, .link_data);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // compare engine: oldest note against what the outputs show now
    always @(posedge clk) begin
        rd_q <= rd;
        if (rd_q) `CHK(rdata, q_reg.pop_front())
        if (smp) `CHK(seen, q_link.pop_front())
    end
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        q_reg.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // reference decode of one complete word
    task automatic apply(input logic [15:0] w);
        logic [9:0] c;
        c = w[11:2];
        last_m = w;
        wake_m = pd_m && w[13:12] != 2'h3;
        pd_m = w[13:12] == 2'h3;
        case (dac_cmd_pkg::op_mode_t'(w[13:12]))
            dac_cmd_pkg::MODE_WRITE_HOLD: in_m[w[15:14]] = c;
            dac_cmd_pkg::MODE_WRITE_UPDATE: begin
                in_m[w[15:14]] = c;
                out_m = in_m;
            end
            dac_cmd_pkg::MODE_WRITE_ALL: begin
                in_m = '{c, c, c, c};
                out_m = in_m;
            end
            default: term_m = (w[15:14] == 2'h3) ? dac_cmd_pkg::TERM_HIGHZ
                                                 : w[15:14];
        endcase
    endtask
    // one frame, then a look at everything it should have left behind
    task automatic frame(input logic [23:0] bits, input int nf);
        lm.send(bits, nf);
        wake_m = 1'b0;
        if (nf >= 16 && en) apply(bits[23:8]);
        repeat (10) @(posedge clk);
        q_link.push_back({out_m[0], out_m[1], out_m[2], out_m[3], pd_m, pd_m ? term_m : 2'h0,
                          !pd_m && !wake_m, wake_m});
        smp <= 1'b1;
        @(posedge clk);
        smp <= 1'b0;
        for (int i = 0; i < 4; i++) rd_reg(8'h10 + 8'(4 * i), 32'(out_m[i]));
        rd_reg(dac_cmd_pkg::REG_LAST_WORD, 32'(last_m));
        if (pd_m) rd_reg(dac_cmd_pkg::REG_STATUS, {27'h0, 2'h0, term_m, 1'b1});
        repeat (125) @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
    // main sequence
    initial begin
        {rst_n, wr, rd, smp, pd_m, wake_m, term_m, last_m, addr, wdata} = '0;
        en = 1'b1;
        ce = 1'b1;
        in_m = '{default: 10'h0};
        out_m = '{default: 10'h0};
        void'($urandom(45870));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        frame(24'h0, 0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) frame({4'(i), 20'($urandom)}, 16);
        frame({4'h1, 12'hfff, 8'h0}, 16);
        frame({4'h1, 12'h000, 8'h0}, 16);
        $display("test modes done");
        frame({4'h9, 20'($urandom)}, 15);
        frame({4'h6, 20'($urandom)}, 22);
        $display("test abort and overrun done");
        wr_reg(dac_cmd_pkg::REG_CTRL, 32'h0);
        en = 1'b0;
        rd_reg(dac_cmd_pkg::REG_CTRL, 32'h0);
        frame({4'h9, 20'($urandom)}, 16);
        wr_reg(dac_cmd_pkg::REG_CTRL, 32'h1);
        en = 1'b1;
        // a write with the clock enable low must not land
        ce <= 1'b0;
        wr_reg(dac_cmd_pkg::REG_CTRL, 32'h0);
        ce <= 1'b1;
        rd_reg(dac_cmd_pkg::REG_CTRL, 32'h1);
        wr_reg(dac_cmd_pkg::REG_LAST_WORD, 32'hffff);
        rd_reg(dac_cmd_pkg::REG_LAST_WORD, 32'(last_m));
        rd_reg(8'h20, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 8; i++) frame(24'($urandom), 16);
        $display("test random done");
        give_verdict();
    end
endmodule // quad_dac_serial_command_port_test
